// ---- testbench.sv ----
// self-checking bench of the vpw link register bank with a reference model
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
	import vpw_pkg::*;
	logic core_clk = 0, sys_rst = 1, txFromCore = 0, sofSeen = 0, breakSeen = 0;
	logic cpuWait = 0, cpuStop = 0, busLvl = 0, inv = 0, rxPin;
	logic rxToCore, rxEnable, txPin, busDriveEn, rxQualified, fsmReset, onchipSel;
	logic rxTruePol, symClkBinary, linkTick, clkRun, irq;
	logic [7:0] regRdata;
	logic [4:0] delayUs;
	logic [1:0] rateSel;
	logic [3:0] protoEvt = 0;
	vpw_req_s req = '0;
	int errors = 0, nTests = 0, nRst = 0, eD, eC1, eC2, eSt, eEn, lkD, lkR, n, p;

	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (fsmReset === 1'b1) nRst++;

	vpw_link_host_registers dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
		.regRdata(regRdata), .rxPin(rxPin), .txFromCore(txFromCore), .sofSeen(sofSeen),
		.breakSeen(breakSeen), .protoEvt(protoEvt), .cpuWait(cpuWait), .cpuStop(cpuStop),
		.rxToCore(rxToCore), .rxEnable(rxEnable), .txPin(txPin), .busDriveEn(busDriveEn),
		.rxQualified(rxQualified), .fsmReset(fsmReset), .delayUs(delayUs),
		.onchipSel(onchipSel), .rxTruePol(rxTruePol), .symClkBinary(symClkBinary),
		.rateSel(rateSel), .linkTick(linkTick), .clkRun(clkRun), .irq(irq));
	vpw_xcvr_model xcvr_u (.txPin(txPin), .busDriveEn(busDriveEn), .busLvl(busLvl),
		.inv(inv), .rxPin(rxPin));

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("errors=%0d checks=%0d", errors, nTests);
		if (errors == 0 && nTests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic rst();
		sys_rst <= 1'b1;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		eD = DELAY_RESET;
		eC1 = CTL1_RESET;
		eC2 = CTL2_RESET;
		eSt = 0;
		eEn = 0;
		lkD = 0;
		lkR = 0;
	endtask

	// gap cycle after each strobe so no signal gets two assignments in one step
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		int t;
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge core_clk);
		req.wr <= 1'b0;
		case (a)
		ADDR_DELAY: if (!lkD) begin
			eD = v & DELAY_WMASK;
			lkD = 1;
		end
		ADDR_CTL1: begin
			t = v & CTL1_WMASK;
			if (lkR) t = (t & 8'hcf) | (eC1 & 8'h30);
			if (eC1[IE_BIT] && !t[IE_BIT]) eSt &= 16;
			if (t[IGNORE_BIT]) eSt = 0;
			eC1 = t;
			lkR = 1;
		end
		ADDR_CTL2: eC2 = v;
		ADDR_CLR: eSt &= ~v;
		ADDR_IEN: eEn = v & 8'h1f;
		default: ;
		endcase
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [2:0] a, input int e);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1;
		`CHK(regRdata, 8'(e))
		@(posedge core_clk);
		#1;
		`CHK(regRdata, 8'h00)
		@(posedge core_clk);
	endtask

	function automatic int ex(int a);
		case (a)
		ADDR_DELAY: return eD;
		ADDR_CTL1: return eC1;
		ADDR_CTL2: return eC2;
		ADDR_STAT: return eSt;
		ADDR_IEN: return eEn;
		default: return 0;
		endcase
	endfunction

	task automatic chkAll();
		for (int a = 0; a < 8; a++) rd(3'(a), ex(a));
		`CHK(delayUs, 5'(9 + eD % 16))
		`CHK({onchipSel, rxTruePol}, 2'(eD >> 6))
		`CHK({rxEnable, symClkBinary, rateSel}, 4'((eC1 >> 4) ^ 8))
		`CHK(irq, !eC1[7] && ((eC1[1] && (eSt & eEn & 15)) || (eSt & eEn & 16)))
	endtask

	task automatic pulse(input logic [3:0] e, input int s);
		protoEvt <= e;
		sofSeen <= (s == 1);
		breakSeen <= (s == 2);
		@(posedge core_clk);
		protoEvt <= 4'h0;
		sofSeen <= 1'b0;
		breakSeen <= 1'b0;
		if (!eC1[7]) eSt |= e;
		if (s != 0) eC1 &= 8'h7f;
		@(posedge core_clk);
	endtask

	// bounded wait: 0 for reception allowed, 1 for bus drive allowed
	task automatic wt(input bit w);
		while ((w ? busDriveEn : rxQualified) !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 400) begin
			errors++;
			complete_run();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(31));
		rst();
		chkAll();
		for (int k = 0; k < 4; k++) begin
			rst();
			n = (k == 0) ? 0 : (k == 3) ? 15 : $urandom % 16;
			wr(ADDR_DELAY, {1'b0, k[0], 2'b00, 4'(n)});
			wr(ADDR_DELAY, 8'hff);
			wr(ADDR_CTL1, {1'b1, k[0], 2'(k), 4'h0});
			wr(ADDR_CTL1, 8'(eC1 ^ 8'h30));
			wr(ADDR_CTL2, 8'h00);
			chkAll();
			n = 0;
			repeat (64) begin
				@(posedge core_clk);
				#1;
				n += linkTick;
			end
			`CHK(n, 64 >> k)
			inv <= !k[0];
			repeat (8) begin
				busLvl <= 1'($urandom);
				repeat (3) @(posedge core_clk);
				#1;
				`CHK(rxToCore, busLvl)
			end
		end
		rst();
		inv <= 1'b0;
		busLvl <= 1'b0;
		wr(ADDR_IEN, 8'h1f);
		wr(ADDR_CTL1, 8'h82);
		pulse(4'h5, 0);
		chkAll();
		pulse(4'h0, 1);
		pulse(4'($urandom % 15 + 1), 0);
		chkAll();
		wr(ADDR_CLR, 8'(eSt & 5));
		chkAll();
		wr(ADDR_IEN, 8'h10);
		chkAll();
		wr(ADDR_IEN, 8'h1f);
		wr(ADDR_CTL1, 8'h00);
		chkAll();
		wr(ADDR_CTL2, 8'h00);
		cpuWait <= 1'b1;
		busLvl <= 1'b1;
		repeat (4) @(posedge core_clk);
		eSt |= 16;
		chkAll();
		wr(ADDR_CTL1, 8'h01);
		n = 0;
		repeat (16) begin
			@(posedge core_clk);
			#1;
			n += linkTick;
		end
		`CHK({clkRun, 5'(n)}, 6'h00)
		cpuWait <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK(clkRun, 1'b1)
		@(posedge core_clk);
		wr(ADDR_CTL1, 8'h80);
		chkAll();
		pulse(4'h0, 2);
		chkAll();
		busLvl <= 1'b0;
		txFromCore <= 1'b1;
		p = nRst;
		wr(ADDR_CTL2, 8'h80);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK({nRst == p + 1, busDriveEn, txPin, rxToCore}, 4'h9)
		@(posedge core_clk);
		txFromCore <= 1'b0;
		wr(ADDR_CTL2, 8'h00);
		n = 0;
		wt(0);
		`CHK(n inside {[EOF_IDLE_TICKS - 4 : EOF_IDLE_TICKS + 4]}, 1'b1)
		`CHK(busDriveEn, 1'b0)
		wt(1);
		`CHK(n inside {[IFS_IDLE_TICKS - 4 : IFS_IDLE_TICKS + 4]}, 1'b1)
		repeat (4) begin
			@(posedge core_clk);
			txFromCore <= 1'($urandom);
			@(posedge core_clk);
			#1;
			`CHK(txPin, txFromCore)
		end
		complete_run();
	end
endmodule

// ---- vpw_link_host_registers.sv ----
// control register bank of the vpw byte data link controller
//
// Summary of operation
// - delay register takes only the first write after reset, always readable
// - delay compensation resets to 16 us, adjustable 9 to 24 us
// - four-bit offset code: 0000 is 9 us, plus one us per step
// - polarity bit 1 passes receive input, 0 inverts it
// - ignore bit disables receiver, masks interrupts, holds status at reset
// - start-of-frame or break clears ignore bit, interrupts then resume
// - symbol clock bit: 1 binary 1.048576 MHz, 0 integer 1 MHz
// - rate bits divide crystal clock by 1, 2, 4 or 8
// - rate bits take only the first write after reset
// - interrupt enable gates run-mode requests, not wake-up requests
// - request holds until sources cleared; clearing enable may drop pending
// - wait clock bit 1 stops internal clocks in cpu wait
// - loopback set: receiver sees drive stage input, bus not driven
// - after loopback clears, drive only after required idle bus time
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module vpw_link_host_registers (
	input wire logic core_clk, // 40 MHz core clock
	input wire logic sys_rst, // synchronous reset, high
	input wire vpw_pkg::vpw_req_s req, // register request
	output logic [7:0] regRdata, // read data, cycle after read
	input wire logic rxPin, // receive pin from transceiver
	input wire logic txFromCore, // transmit level from protocol logic
	input wire logic sofSeen, // start-of-frame received pulse
	input wire logic breakSeen, // break symbol received pulse
	input wire logic [3:0] protoEvt, // protocol event pulses
	input wire logic cpuWait, // cpu in wait mode
	input wire logic cpuStop, // cpu in stop mode
	output logic rxToCore, // receive level to protocol logic
	output logic rxEnable, // receiver enabled
	output logic txPin, // drive level to transceiver
	output logic busDriveEn, // bus may be driven
	output logic rxQualified, // reception allowed after idle
	output logic fsmReset, // protocol state reset pulse
	output logic [4:0] delayUs, // expected transceiver delay in us
	output logic onchipSel, // on-chip transceiver select
	output logic rxTruePol, // receive polarity true
	output logic symClkBinary, // binary symbol clock assumed
	output logic [1:0] rateSel, // crystal clock divider code
	output logic linkTick, // link timing clock enable pulse
	output logic clkRun, // internal clocks running
	output logic irq // interrupt request level
);
	import vpw_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [2:0] div_last(input logic [1:0] rate);
		logic [2:0] r;
		r = 3'h0;
		unique case (rate)
			2'h0: r = 3'h0;
			2'h1: r = 3'h1;
			2'h2: r = 3'h3;
			2'h3: r = 3'h7;
		endcase
		return r;
	endfunction

	vpw_state_s stQ;
	vpw_state_s stD;
	logic wrDelay;
	logic wrCtl1;
	logic wrCtl2;
	logic wrClr;
	logic wrIen;
	logic loopback;
	logic ignoreMsg;
	logic rxTrue;
	logic sleeping;
	logic [N_EVT-1:0] evtSet;
	logic [7:0] ctl1New;

	assign wrDelay = req.wr && (req.addr == ADDR_DELAY);
	assign wrCtl1 = req.wr && (req.addr == ADDR_CTL1);
	assign wrCtl2 = req.wr && (req.addr == ADDR_CTL2);
	assign wrClr = req.wr && (req.addr == ADDR_CLR);
	assign wrIen = req.wr && (req.addr == ADDR_IEN);
	assign loopback = stQ.ctl2[LOOP_BIT];
	assign ignoreMsg = stQ.ctl1[IGNORE_BIT];
	// inverting transceivers are undone here so the core sees true bus level
	assign rxTrue = stQ.delayCfg[TRUEPOL_BIT] ? stQ.rxS2 : ~stQ.rxS2;
	assign sleeping = cpuStop || cpuWait;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		stD = stQ;
		stD.rxS1 = rxPin;
		stD.rxS2 = stQ.rxS1;
		stD.rxPrev = stQ.rxS2;
		stD.fsmRst = 1'b0;
		stD.tick = 1'b0;
		stD.rdData = 8'h00;
		ctl1New = stQ.ctl1;
		evtSet = '0;

		// prescaler stops with the internal clocks
		if (clkRun) begin
			if (stQ.divCnt >= div_last(rateSel)) begin
				stD.divCnt = 3'h0;
				stD.tick = 1'b1;
			end else begin
				stD.divCnt = stQ.divCnt + 3'h1;
			end
		end

		// whole register freezes after its first write
		if (wrDelay && !stQ.delayLocked) begin
			stD.delayCfg = req.wdata & DELAY_WMASK;
			stD.delayLocked = 1'b1;
		end

		if (wrCtl1) begin
			ctl1New = req.wdata & CTL1_WMASK;
			if (stQ.rateLocked) begin
				ctl1New[RATE_HI_BIT] = stQ.ctl1[RATE_HI_BIT];
				ctl1New[RATE_LO_BIT] = stQ.ctl1[RATE_LO_BIT];
			end
			stD.ctl1 = ctl1New;
			stD.rateLocked = 1'b1;
		end
		// frame start beats a same-cycle software set, so no frame is missed
		if (sofSeen || breakSeen) begin
			stD.ctl1[IGNORE_BIT] = 1'b0;
		end

		if (wrCtl2) begin
			stD.ctl2 = req.wdata;
			if (req.wdata[LOOP_BIT] && !loopback) begin
				stD.fsmRst = 1'b1;
			end
		end

		if (wrIen) begin
			stD.irqEn = req.wdata[N_EVT-1:0];
		end

		// sticky status: set wins over the clear
		evtSet[3:0] = protoEvt;
		evtSet[WAKE_BIT] = sleeping && (stQ.rxS2 != stQ.rxPrev);
		if (wrClr) begin
			stD.status = stQ.status & ~req.wdata[N_EVT-1:0];
		end
		stD.status = stD.status | evtSet;
		// dropping enable discards pending run-mode requests
		if (wrCtl1 && stQ.ctl1[IE_BIT] && !req.wdata[IE_BIT]) begin
			stD.status = stD.status & ~PROTO_EVT_MASK;
		end
		// also cleared on the edge that sets the bit, so status never shows while ignoring
		if (ignoreMsg || stD.ctl1[IGNORE_BIT]) begin
			stD.status = '0;
		end

		// idle qualification after loopback is released
		if (loopback) begin
			stD.idleCnt = 10'h000;
			stD.rxOk = 1'b0;
			stD.txOk = 1'b0;
		end else if (!(stQ.rxOk && stQ.txOk)) begin
			if (rxTrue) begin
				stD.idleCnt = 10'h000;
			end else if (linkTick && (stQ.idleCnt != IDLE_CNT_MAX)) begin
				stD.idleCnt = stQ.idleCnt + 10'h001;
			end
			if (stQ.idleCnt >= EOF_IDLE_TICKS) begin
				stD.rxOk = 1'b1;
			end
			if (stQ.idleCnt >= IFS_IDLE_TICKS) begin
				stD.txOk = 1'b1;
			end
		end

		// read data stands only in the cycle after the strobe
		if (req.rd) begin
			unique case (req.addr)
				ADDR_DELAY: stD.rdData = stQ.delayCfg;
				ADDR_CTL1: stD.rdData = stQ.ctl1;
				ADDR_CTL2: stD.rdData = stQ.ctl2;
				ADDR_STAT: stD.rdData = {3'h0, stQ.status};
				ADDR_IEN: stD.rdData = {3'h0, stQ.irqEn};
				default: stD.rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stQ <= ST_RESET;
		end else begin
			stQ <= stD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign regRdata = stQ.rdData;
	assign delayUs = DELAY_BASE_US + {1'b0, stQ.delayCfg[3:0]};
	// only passed on; software must keep it clear
	assign onchipSel = stQ.delayCfg[ONCHIP_BIT];
	assign rxTruePol = stQ.delayCfg[TRUEPOL_BIT];
	assign symClkBinary = stQ.ctl1[SYMCLK_BIT];
	assign rateSel = {stQ.ctl1[RATE_HI_BIT], stQ.ctl1[RATE_LO_BIT]};
	assign clkRun = !(cpuWait && stQ.ctl1[WAITSTOP_BIT]);
	assign linkTick = stQ.tick && clkRun;
	assign rxEnable = !ignoreMsg;
	assign rxToCore = loopback ? txFromCore : rxTrue;
	assign busDriveEn = !loopback && stQ.txOk;
	assign txPin = busDriveEn && txFromCore;
	assign rxQualified = !loopback && stQ.rxOk;
	assign fsmReset = stQ.fsmRst;
	// wake-up requests bypass the run-mode enable
	assign irq = !ignoreMsg && (
		(stQ.ctl1[IE_BIT] && |(stQ.status[3:0] & stQ.irqEn[3:0])) ||
		(stQ.status[WAKE_BIT] && stQ.irqEn[WAKE_BIT]));

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_tick_gap;
		!linkTick [*7];
	endsequence

	// prescaler only advances while the internal clocks run
	sequence s_run8;
		clkRun [*8];
	endsequence

	sequence s_loop_release;
		$fell(loopback);
	endsequence

	sequence s_loop_request;
		wrCtl2 && req.wdata[LOOP_BIT] && !loopback;
	endsequence

	sequence s_clear_run;
		wrClr && !ignoreMsg;
	endsequence

	a_delay_once: assert property (stQ.delayLocked && wrDelay |=> $stable(stQ.delayCfg))
		else $error("delay register changed after lock");
	a_delay_reset: assert property ($past(sys_rst) |-> delayUs == 5'h10)
		else $error("delay not 16 us after reset");
	a_delay_range: assert property (delayUs >= 5'h09 && delayUs <= 5'h18)
		else $error("delay outside 9 to 24 us");
	a_rx_polarity: assert property (!loopback |-> rxToCore == (rxTruePol ~^ stQ.rxS2))
		else $error("receive polarity wrong");
	a_ignore_mask: assert property (ignoreMsg |-> !irq && stQ.status == '0)
		else $error("request while ignoring message");
	a_ignore_clear: assert property (sofSeen |=> !ignoreMsg)
		else $error("ignore bit not cleared by frame start");
	a_tick_div8: assert property (linkTick && rateSel == 2'h3 ##1 s_run8 |-> linkTick)
		else $error("divide by eight tick spacing wrong");
	a_tick_gap: assert property (linkTick && rateSel == 2'h3 |=> s_tick_gap)
		else $error("tick too early at divide by eight");
	a_rate_once: assert property (stQ.rateLocked && wrCtl1 |=> $stable(rateSel))
		else $error("rate bits changed after lock");
	a_irq_hold: assert property (irq && !req.wr |=> irq)
		else $error("request dropped without register action");
	a_wait_stop: assert property (cpuWait && stQ.ctl1[WAITSTOP_BIT] |-> !clkRun && !linkTick)
		else $error("clocks running in wait");
	a_loop_nodrive: assert property (loopback |-> !busDriveEn && !txPin)
		else $error("bus driven in loopback");
	a_idle_drive: assert property ($fell(loopback) |-> !busDriveEn [*2])
		else $error("bus driven before idle time");

	////////////////////////////////////////////////////////////////////////
	// register port

	a_rdata_idle: assert property (!req.rd |=> regRdata == 8'h00)
		else $error("read data outside its cycle");
	a_rdata_delay: assert property (req.rd && req.addr == ADDR_DELAY
		|=> regRdata == $past(stQ.delayCfg))
		else $error("delay register read wrong");
	a_rdata_ctl1: assert property (req.rd && req.addr == ADDR_CTL1
		|=> regRdata == $past(stQ.ctl1))
		else $error("control one read wrong");
	a_rdata_ctl2: assert property (req.rd && req.addr == ADDR_CTL2
		|=> regRdata == $past(stQ.ctl2))
		else $error("control two read wrong");

	////////////////////////////////////////////////////////////////////////
	// delay register

	a_delay_lock: assert property (wrDelay |=> stQ.delayLocked)
		else $error("delay register not locked by write");
	a_delay_low: assert property (stQ.delayCfg[3:0] == 4'h0 |-> delayUs == 5'h09)
		else $error("code zero not 9 us");
	a_delay_high: assert property (stQ.delayCfg[3:0] == 4'hf |-> delayUs == 5'h18)
		else $error("code fifteen not 24 us");

	////////////////////////////////////////////////////////////////////////
	// control one

	a_ignore_set: assert property (wrCtl1 && req.wdata[IGNORE_BIT] && !sofSeen
		&& !breakSeen |=> !rxEnable)
		else $error("receiver left enabled while ignoring");
	a_break_clear: assert property (breakSeen |=> !ignoreMsg)
		else $error("ignore bit not cleared by break");
	a_symclk_wr: assert property (wrCtl1 |=> symClkBinary == $past(req.wdata[SYMCLK_BIT]))
		else $error("symbol clock bit not written");
	a_tick_div1: assert property (rateSel == 2'h0 && $past(rateSel) == 2'h0
		&& $past(clkRun) && clkRun && !$past(sys_rst) |-> linkTick)
		else $error("undivided tick missing");
	a_rate_lock: assert property (wrCtl1 |=> stQ.rateLocked)
		else $error("rate bits not locked by write");

	////////////////////////////////////////////////////////////////////////
	// interrupts and clocks

	a_irq_gate: assert property (!stQ.ctl1[IE_BIT] && !stQ.status[WAKE_BIT] |-> !irq)
		else $error("run-mode request while disabled");
	a_irq_wake: assert property (!ignoreMsg && stQ.status[WAKE_BIT]
		&& stQ.irqEn[WAKE_BIT] |-> irq)
		else $error("wake request not raised");
	a_clr_set_wins: assert property (s_clear_run
		|=> (stQ.status[3:0] & $past(protoEvt)) == $past(protoEvt))
		else $error("same-cycle event lost to clear");
	a_wait_run: assert property (!cpuWait |-> clkRun)
		else $error("clocks stopped outside wait");
	a_wait_keep: assert property (cpuWait && !stQ.ctl1[WAITSTOP_BIT] |-> clkRun)
		else $error("clocks stopped though wait stop clear");

	////////////////////////////////////////////////////////////////////////
	// loopback and idle qualification

	a_loop_rx: assert property (loopback |-> rxToCore == txFromCore)
		else $error("loopback path not to receiver");
	a_loop_fsm: assert property (s_loop_request |=> fsmReset)
		else $error("no state reset on loopback set");
	a_fsm_pulse: assert property (fsmReset |=> !fsmReset)
		else $error("state reset longer than one cycle");
	a_idle_rx0: assert property (s_loop_release |-> !rxQualified)
		else $error("reception allowed at loopback release");
	a_idle_eof: assert property ($rose(rxQualified)
		|-> $past(stQ.idleCnt) >= EOF_IDLE_TICKS)
		else $error("reception allowed before end-of-frame idle");
	a_idle_ifs: assert property ($rose(busDriveEn)
		|-> $past(stQ.idleCnt) >= IFS_IDLE_TICKS)
		else $error("drive allowed before inter-frame idle");

endmodule

// ---- vpw_pkg.sv ----
// register map, field layout, reset values and carriers of the vpw link register bank
package vpw_pkg;

	////////////////////////////////////////////////////////////////////////
	// register addresses
	localparam logic [2:0] ADDR_DELAY = 3'h0;
	localparam logic [2:0] ADDR_CTL1 = 3'h1;
	localparam logic [2:0] ADDR_CTL2 = 3'h2;
	localparam logic [2:0] ADDR_STAT = 3'h3;
	localparam logic [2:0] ADDR_CLR = 3'h4;
	localparam logic [2:0] ADDR_IEN = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned ONCHIP_BIT = 7;
	localparam int unsigned TRUEPOL_BIT = 6;
	localparam int unsigned IGNORE_BIT = 7;
	localparam int unsigned SYMCLK_BIT = 6;
	localparam int unsigned RATE_HI_BIT = 5;
	localparam int unsigned RATE_LO_BIT = 4;
	localparam int unsigned IE_BIT = 1;
	localparam int unsigned WAITSTOP_BIT = 0;
	localparam int unsigned LOOP_BIT = 7;
	localparam int unsigned WAKE_BIT = 4;
	localparam int unsigned N_EVT = 5;

	////////////////////////////////////////////////////////////////////////
	// reset values and write masks
	localparam logic [7:0] DELAY_RESET = 8'h47;
	localparam logic [7:0] DELAY_WMASK = 8'hcf;
	localparam logic [7:0] CTL1_RESET = 8'h80;
	localparam logic [7:0] CTL1_WMASK = 8'hf3;
	localparam logic [7:0] CTL2_RESET = 8'h80;
	localparam logic [N_EVT-1:0] PROTO_EVT_MASK = 5'h0f;

	////////////////////////////////////////////////////////////////////////
	// timing: delay code base, idle times counted in link timing ticks
	localparam logic [4:0] DELAY_BASE_US = 5'h09;
	localparam logic [9:0] TICKS_PER_US = 10'h001;
	localparam logic [9:0] EOF_IDLE_US = 10'h0c8;
	localparam logic [9:0] IFS_IDLE_US = 10'h0fa;
	localparam logic [9:0] EOF_IDLE_TICKS = 10'(EOF_IDLE_US * TICKS_PER_US);
	localparam logic [9:0] IFS_IDLE_TICKS = 10'(IFS_IDLE_US * TICKS_PER_US);
	localparam logic [9:0] IDLE_CNT_MAX = 10'h3ff;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} vpw_req_s;

	typedef struct packed {
		logic [7:0] delayCfg;
		logic delayLocked;
		logic [7:0] ctl1;
		logic rateLocked;
		logic [7:0] ctl2;
		logic [N_EVT-1:0] status;
		logic [N_EVT-1:0] irqEn;
		logic [7:0] rdData;
		logic rxS1;
		logic rxS2;
		logic rxPrev;
		logic [2:0] divCnt;
		logic tick;
		logic [9:0] idleCnt;
		logic rxOk;
		logic txOk;
		logic fsmRst;
	} vpw_state_s;

	localparam vpw_state_s ST_RESET = '{
		delayCfg: DELAY_RESET,
		ctl1: CTL1_RESET,
		ctl2: CTL2_RESET,
		default: '0
	};

endpackage

// ---- vpw_xcvr_model.sv ----
// behavioural model of the off-chip bus transceiver beside the link
`timescale 1ns/1ps
module vpw_xcvr_model (
	input wire logic txPin, // drive level from the link
	input wire logic busDriveEn, // link drives the bus
	input wire logic busLvl, // level forced by the other nodes
	input wire logic inv, // receive path inverts the bus
	output logic rxPin // receive level to the link
);
	// wired-or bus: any active node pulls it high, so the link sees its own drive too
	always_comb begin
		rxPin = (busLvl | (busDriveEn & txPin)) ^ inv;
	end
endmodule
